// ### core/switch_irq_agg.sv
// Top: per-partition interrupt generation and upstream INTx aggregation

// Operation
// - Unmasked rise with MSI enabled sends MSI
// - Legacy enabled rise requests Assert_INTA to core
// - Legacy enabled fall requests Deassert_INTA to core
// - Condition ends when sources masked or cleared
// - All port MSIs forwarded to upstream port
// - Sources: hot-plug and enabled bandwidth status
// - Port's own legacy interrupts use INTA only
// - Aggregated state kept per line per port
// - Upstream Assert_INTx on aggregate rising
// - Upstream Deassert_INTx on aggregate falling
// - Downstream bridges apply no line remap
// - Upstream remaps line y to (y+N) mod 4
// - Remap covers external and port interrupts
// - Link down or removal negates port wires
module switch_irq_agg
	import irq_agg_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  reset,
	input  wire dsp_cfg_s [NUM_DSP-1:0] dsp_cfg,
	output logic [NUM_DSP-1:0]         msi_fwd,
	output intx_msg_s [NUM_DSP-1:0]    core_req,
	output logic [NUM_DSP-1:0][3:0]    port_intx,
	output logic [3:0]                 up_intx,
	output intx_msg_s                  root_msg
);
	logic [NUM_DSP-1:0]      msi_req;
	logic [NUM_DSP-1:0]      own_inta;
	logic [NUM_DSP-1:0][3:0] next_port_intx;
	logic [3:0]              next_up_intx;
	logic [3:0]              root_pend;
	logic [1:0]              pick;
	logic                    pick_ok;

	// ==========================================================
	// Downstream port generators
	genvar g;
	generate
		for (g = 0; g < NUM_DSP; g++) begin : g_dsp
			dsp_irq_gen u_gen (
				.mclk     (mclk),
				.reset    (reset),
				.cfg      (dsp_cfg[g]),
				.msi_req  (msi_req[g]),
				.own_inta (own_inta[g]),
				.core_req (core_req[g])
			);
		end
	endgenerate

	// MSIs all target the root; software keeps the address sane
	always_ff @(posedge mclk) begin
		if (reset) begin
			msi_fwd <= '0;
		end else begin
			msi_fwd <= msi_req;
		end
	end

	// ==========================================================
	// Per-port wires and swizzle to upstream lines
	always_comb begin
		next_up_intx = LINES_RESET;
		for (int p = 0; p < NUM_DSP; p++) begin
			// No remap at the downstream bridge: device zero below
			next_port_intx[p] = dsp_cfg[p].ext_intx
				| {3'h0, own_inta[p]};
			if (!(dsp_cfg[p].dl_up && dsp_cfg[p].in_partition)) begin
				next_port_intx[p] = 4'h0;
			end
			for (int y = 0; y < NUM_LINES; y++) begin
				next_up_intx[2'(y + int'(dsp_cfg[p].dev_num))] =
					next_up_intx[2'(y + int'(dsp_cfg[p].dev_num))]
					| next_port_intx[p][y];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			port_intx <= '0;
			up_intx   <= LINES_RESET;
		end else begin
			port_intx <= next_port_intx;
			up_intx   <= next_up_intx;
		end
	end

	// ==========================================================
	// Upstream message issue: one message per cycle, lowest line first.
	// A line toggling back before its message goes out cancels both.
	always_comb begin
		pick    = 2'h0;
		pick_ok = 1'b0;
		for (int y = NUM_LINES - 1; y >= 0; y--) begin
			if (root_pend[y]) begin
				pick    = 2'(y);
				pick_ok = 1'b1;
			end
		end
	end

	logic [3:0] sent_state;

	always_ff @(posedge mclk) begin
		if (reset) begin
			sent_state <= LINES_RESET;
			root_msg   <= '0;
		end else begin
			root_msg <= '0;
			if (pick_ok) begin
				sent_state[pick]    <= up_intx[pick];
				root_msg.valid      <= 1'b1;
				root_msg.assert_msg <= up_intx[pick];
				root_msg.line       <= pick;
			end
		end
	end

	assign root_pend = up_intx ^ sent_state;

	// ==========================================================
	// Upstream message checks
	// Line A wins the issue priority, so its edges go out next cycle
	AST_ASSERT_MSG: assert property (@(posedge mclk)
		disable iff (reset) root_msg.valid & root_msg.assert_msg
		|-> (($past(up_intx) >> root_msg.line) & 4'h1) == 4'h1)
		else $error("Assert_INTx without asserted aggregate");

	AST_DEASSERT_MSG: assert property (@(posedge mclk)
		disable iff (reset) root_msg.valid & !root_msg.assert_msg
		|-> (($past(up_intx) >> root_msg.line) & 4'h1) == 4'h0)
		else $error("Deassert_INTx without negated aggregate");

	AST_PEND_SERVED: assert property (@(posedge mclk)
		disable iff (reset) $rose(up_intx[0]) ##0 !root_pend[1]
		&& !root_pend[2] && !root_pend[3] |=> root_msg.valid)
		else $error("Aggregate change not reported");

	AST_FALL_SERVED: assert property (@(posedge mclk)
		disable iff (reset) $fell(up_intx[0])
		|=> root_msg.valid && !root_msg.assert_msg
		&& root_msg.line == 2'h0)
		else $error("Line A negation not reported");

	AST_NO_CHANGE_QUIET: assert property (@(posedge mclk)
		disable iff (reset) root_pend == 4'h0 |=> !root_msg.valid)
		else $error("Message without aggregate change");

	// ==========================================================
	// Per-port wire checks, on port 0 which sees device numbers 0 to 3
	AST_DOWN_CLEARS: assert property (@(posedge mclk)
		disable iff (reset) !dsp_cfg[0].dl_up |=> port_intx[0] == 4'h0)
		else $error("Down port keeps virtual wires");

	AST_OUT_CLEARS: assert property (@(posedge mclk)
		disable iff (reset)
		!dsp_cfg[0].in_partition |=> port_intx[0] == 4'h0)
		else $error("Removed port keeps virtual wires");

	AST_NO_DSP_REMAP: assert property (@(posedge mclk)
		disable iff (reset) dsp_cfg[0].dl_up & dsp_cfg[0].in_partition
		|=> port_intx[0][3:1] == $past(dsp_cfg[0].ext_intx[3:1]))
		else $error("Downstream bridge remapped a line");

	// ==========================================================
	// Swizzle and aggregation checks
	AST_SWIZZLE_DEV0: assert property (@(posedge mclk)
		disable iff (reset) dsp_cfg[0].dl_up & dsp_cfg[0].in_partition
		& dsp_cfg[0].dev_num == 5'h00 & dsp_cfg[0].ext_intx[2]
		|=> up_intx[2])
		else $error("Line C of device 0 not on upstream C");

	AST_SWIZZLE_DEV1: assert property (@(posedge mclk)
		disable iff (reset) dsp_cfg[0].dl_up & dsp_cfg[0].in_partition
		& dsp_cfg[0].dev_num == 5'h01 & dsp_cfg[0].ext_intx[3]
		|=> up_intx[0])
		else $error("Line D of device 1 not on upstream A");

	AST_SWIZZLE_DEV2: assert property (@(posedge mclk)
		disable iff (reset) dsp_cfg[0].dl_up & dsp_cfg[0].in_partition
		& dsp_cfg[0].dev_num == 5'h02 & dsp_cfg[0].ext_intx[0]
		|=> up_intx[2])
		else $error("Line A of device 2 not on upstream C");

	AST_SWIZZLE_DEV3: assert property (@(posedge mclk)
		disable iff (reset) dsp_cfg[0].dl_up & dsp_cfg[0].in_partition
		& dsp_cfg[0].dev_num == 5'h03 & dsp_cfg[0].ext_intx[1]
		|=> up_intx[0])
		else $error("Line B of device 3 not on upstream A");

	AST_OWN_SWIZZLED: assert property (@(posedge mclk)
		disable iff (reset) $past(dsp_cfg[2].dev_num[1:0]) == 2'h3
		& port_intx[2][0] |-> up_intx[3])
		else $error("Port own interrupt not swizzled");

	AST_UP_IS_OR: assert property (@(posedge mclk)
		disable iff (reset) port_intx != '0 |-> up_intx != 4'h0)
		else $error("Port wire missing from aggregate");

	AST_UP_HAS_SOURCE: assert property (@(posedge mclk)
		disable iff (reset) up_intx != 4'h0 |-> port_intx != '0)
		else $error("Aggregate set without a port wire");

	// ==========================================================
	// Generator output checks
	AST_CORE_LINE_A: assert property (@(posedge mclk)
		disable iff (reset) core_req[2].valid |-> core_req[2].line == LINE_A)
		else $error("Port legacy request not on line A");

	AST_CORE_LINE_A3: assert property (@(posedge mclk)
		disable iff (reset)
		core_req[3].valid |-> core_req[3].line == LINE_A)
		else $error("Port legacy request not on line A");

	AST_MSI_FORWARD: assert property (@(posedge mclk)
		disable iff (reset) msi_req[1] |=> msi_fwd[1])
		else $error("MSI not forwarded upstream");

	AST_MSI_PULSE: assert property (@(posedge mclk)
		disable iff (reset) msi_fwd[1] |=> !msi_fwd[1])
		else $error("MSI forwarded twice for one rise");
endmodule // switch_irq_agg

// ### shared/irq_agg_pkg.sv
// Package: constants and carrier types for switch interrupt aggregation
package irq_agg_pkg;
	localparam int NUM_DSP = 4;
	localparam int NUM_LINES = 4;
	localparam int DEV_W = 5;
	localparam logic [3:0] LINES_RESET = 4'h0;
	localparam logic [1:0] LINE_A = 2'h0;

	// Per-downstream-port configuration and status
	typedef struct packed {
		logic       msi_enable;
		logic       legacy_irq_disable;
		logic       hp_event;
		logic       hp_enable;
		logic       link_bw_mgmt_status;
		logic       link_bw_mgmt_irq_en;
		logic       link_autonomous_bw_status;
		logic       link_autonomous_bw_irq_en;
		logic       dl_up;
		logic       in_partition;
		logic [4:0] dev_num;
		logic [3:0] ext_intx;
	} dsp_cfg_s;

	// One-cycle message request toward the core / root
	typedef struct packed {
		logic       valid;
		logic       assert_msg;
		logic [1:0] line;
	} intx_msg_s;
endpackage

// ### core/dsp_irq_gen.sv
// Downstream port interrupt source and MSI/INTA generation
module dsp_irq_gen
	import irq_agg_pkg::*;
(
	input  wire logic     mclk,
	input  wire logic     reset,
	input  wire dsp_cfg_s cfg,
	output logic          msi_req,
	output logic          own_inta,
	output intx_msg_s     core_req
);
	logic cond;
	logic cond_q;
	logic live;

	// Condition holds while any unmasked source bit stays set
	assign cond = (cfg.hp_event & cfg.hp_enable)
		| (cfg.link_bw_mgmt_status & cfg.link_bw_mgmt_irq_en)
		| (cfg.link_autonomous_bw_status
			& cfg.link_autonomous_bw_irq_en);
	assign live = cfg.dl_up & cfg.in_partition;

	// ==========================================================
	// Edge tracking
	always_ff @(posedge mclk) begin
		if (reset) begin
			cond_q <= 1'b0;
		end else begin
			cond_q <= cond;
		end
	end

	// ==========================================================
	// Message requests
	always_ff @(posedge mclk) begin
		if (reset) begin
			msi_req  <= 1'b0;
			core_req <= '0;
		end else begin
			msi_req  <= cond & ~cond_q & cfg.msi_enable;
			core_req <= '0;
			if (!cfg.msi_enable && !cfg.legacy_irq_disable
				&& (cond != cond_q)) begin
				core_req.valid      <= 1'b1;
				core_req.assert_msg <= cond;
				core_req.line       <= LINE_A;
			end
		end
	end

	// Own virtual wire, line A only; dropped when the link goes down
	always_ff @(posedge mclk) begin
		if (reset) begin
			own_inta <= 1'b0;
		end else if (!live) begin
			own_inta <= 1'b0;
		end else if (!cfg.msi_enable && !cfg.legacy_irq_disable) begin
			own_inta <= cond;
		end else if (cfg.msi_enable || cfg.legacy_irq_disable) begin
			own_inta <= own_inta & ~cfg.legacy_irq_disable;
		end
	end

	AST_MSI_ON_RISE: assert property (@(posedge mclk)
		disable iff (reset) cond & ~cond_q & cfg.msi_enable |=> msi_req)
		else $error("MSI not raised on condition rise");
	AST_NO_INTA_DISABLED: assert property (@(posedge mclk)
		disable iff (reset)
		cfg.legacy_irq_disable | cfg.msi_enable |=> !core_req.valid)
		else $error("Legacy request while disabled");
	AST_DEASSERT_ON_FALL: assert property (@(posedge mclk)
		disable iff (reset)
		!cond & cond_q & !cfg.msi_enable & !cfg.legacy_irq_disable
		|=> core_req.valid & !core_req.assert_msg)
		else $error("Deassert request missing");
endmodule // dsp_irq_gen

// ### sim/root_model.sv
// Root complex model tracking upstream INTx wires from messages
module root_model
	import irq_agg_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      reset,
	input  wire intx_msg_s msg,
	output logic [3:0]     lines,
	output logic           bad
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Wire state
	// A repeated message for a line means an edge was reported twice
	always_ff @(posedge mclk) begin
		if (reset) begin
			lines <= LINES_RESET;
			bad <= 1'h0;
		end else if (msg.valid) begin
			lines[msg.line] <= msg.assert_msg;
			if (lines[msg.line] == msg.assert_msg)
				bad <= 1'h1;
		end
	end
endmodule // root_model

// ### sim/testbench.sv
// Testbench for switch interrupt aggregation
module testbench
	import irq_agg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic                    mclk;
	logic                    reset;
	dsp_cfg_s [NUM_DSP-1:0]  cfg;
	logic [NUM_DSP-1:0]      msi_fwd;
	intx_msg_s [NUM_DSP-1:0] core_req;
	logic [NUM_DSP-1:0][3:0] port_intx;
	logic [3:0]              up_intx;
	intx_msg_s               root_msg;
	logic [3:0]              root_lines;
	logic                    root_bad;
	int                      failures;
	int                      n_tests;
	switch_irq_agg switch_irq_agg_inst (.mclk(mclk), .reset(reset),
		.dsp_cfg(cfg), .msi_fwd(msi_fwd), .core_req(core_req),
		.port_intx(port_intx), .up_intx(up_intx), .root_msg(root_msg));
	root_model root_model_inst (.mclk(mclk), .reset(reset),
		.msg(root_msg), .lines(root_lines), .bad(root_bad));
	// ==========================================
	// Helpers
	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// Inputs change 1 ns after an edge, outputs are read then too
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic idle;
		for (int p = 0; p < NUM_DSP; p++) begin
			cfg[p] = '0;
			cfg[p].dl_up = 1'h1;
			cfg[p].in_partition = 1'h1;
		end
	endtask
	task automatic conclude;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task automatic test_msi;
		// Software has aimed the MSI address upstream, clear of multicast
		cfg[1].msi_enable = 1'h1;
		cfg[1].legacy_irq_disable = 1'h1;
		cfg[1].hp_enable = 1'h1;
		tick(1);
		cfg[1].hp_event = 1'h1;
		tick(1);
		check(4'(core_req[1]), 4'h0);
		tick(1);
		check(msi_fwd, 4'h2);
		cfg[1].hp_event = 1'h0;
		tick(2);
		check(4'(core_req[1]) | msi_fwd, 4'h0);
		check(port_intx[1], 4'h0);
		$display("test msi done");
	endtask
	task automatic test_legacy;
		cfg[2].dev_num = 5'h07;
		cfg[2].link_bw_mgmt_status = 1'h1;
		tick(1);
		check(4'(core_req[2]), 4'h0);
		cfg[2].link_bw_mgmt_irq_en = 1'h1;
		tick(1);
		check(4'(core_req[2]), 4'hC);
		tick(1);
		check(port_intx[2], 4'h1);
		check(up_intx, 4'h8);
		tick(1);
		check(4'(root_msg), 4'hF);
		cfg[2].link_bw_mgmt_irq_en = 1'h0;
		tick(1);
		check(4'(core_req[2]), 4'h8);
		tick(3);
		check(up_intx | root_lines, 4'h0);
		$display("test legacy done");
	endtask
	task automatic test_disable;
		cfg[3].legacy_irq_disable = 1'h1;
		cfg[3].link_autonomous_bw_irq_en = 1'h1;
		cfg[3].link_autonomous_bw_status = 1'h1;
		tick(1);
		check(4'(core_req[3]), 4'h0);
		tick(2);
		check(msi_fwd | port_intx[3], 4'h0);
		cfg[3].legacy_irq_disable = 1'h0;
		tick(2);
		check(port_intx[3], 4'h1);
		$display("test disable done");
	endtask
	task automatic test_remap;
		for (int n = 0; n < 4; n++)
			for (int y = 0; y < 4; y++) begin
				cfg[0].dev_num = 5'(n);
				cfg[0].ext_intx = 4'h1 << y;
				tick(4);
				check(port_intx[0], 4'h1 << y);
				check(up_intx, 4'h1 << ((y + n) % 4));
				check(root_lines, 4'h1 << ((y + n) % 4));
			end
		cfg[0].dev_num = 5'h00;
		cfg[0].ext_intx = 4'h2;
		cfg[1].dev_num = 5'h01;
		cfg[1].ext_intx = 4'h1;
		tick(4);
		cfg[0].ext_intx = 4'h0;
		tick(4);
		check(up_intx, 4'h2);
		$display("test remap done");
	endtask
	task automatic test_down;
		for (int k = 0; k < 2; k++) begin
			idle();
			cfg[0].ext_intx = 4'hF;
			tick(4);
			check(up_intx, 4'hF);
			if (k == 0)
				cfg[0].dl_up = 1'h0;
			else
				cfg[0].in_partition = 1'h0;
			tick(6);
			check(port_intx[0] | up_intx | root_lines, 4'h0);
		end
		$display("test down done");
	endtask
	// ==========================================
	// Run
	initial begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		#20us;
		failures++;
		conclude();
	end
	initial begin
		failures = 0;
		n_tests = 0;
		reset = 1'h1;
		idle();
		tick(2);
		reset = 1'h0;
		check(up_intx | msi_fwd | 4'(root_msg), 4'h0);
		test_msi();
		idle();
		test_legacy();
		idle();
		test_disable();
		idle();
		test_remap();
		test_down();
		check({3'h0, root_bad}, 4'h0);
		conclude();
	end
endmodule // testbench
